// >>> src/flash_seq_defines.svh
// Instruction codes, geometry and timing constants of the serial flash sequencer.
// Assumes a 50 ns system clock; the long cycle counts are only defaults of parameters.
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

`define CMD_WRITE_UNLOCK 8'h10
`define CMD_FAST_FETCH   8'h20
`define CMD_PAGE_WRITE   8'h30
`define CMD_REGION_WIPE  8'h40
`define CMD_FULL_WIPE    8'h50
`define CMD_SLEEP        8'h60
`define CMD_WAKE         8'h70

`define ADDR_BITS   17
`define PAGE_BITS   8
`define SECTOR_BITS 15
`define ERASED_BYTE 8'hFF

`define CLK_PERIOD_NS 50
`define T_SLEEP_NS    3000
`define T_SLEEP_CYC   ((`T_SLEEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_WAKE_NS     3000
`define T_WAKE_CYC    ((`T_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_PP_US       1000
`define T_PP_CYC      (`T_PP_US * (1000 / `CLK_PERIOD_NS))
`define T_SE_US       500000
`define T_SE_CYC      (`T_SE_US * (1000 / `CLK_PERIOD_NS))
`define T_BE_US       2000000
`define T_BE_CYC      (`T_BE_US * (1000 / `CLK_PERIOD_NS))

`endif

// >>> src/flash_seq_pkg.sv
// Types shared by the serial flash sequencer and its bench.
// Assumes nothing beyond a SystemVerilog compiler.
package flash_seq_pkg;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic sdi;
   } link_pins_type;

   typedef struct packed {
      logic hi;
      logic lo;
   } guard_type;

   typedef enum logic [5:0] {
      PH_CMD   = 6'b000001,
      PH_ADDR  = 6'b000010,
      PH_DUMMY = 6'b000100,
      PH_DATA  = 6'b001000,
      PH_DONE  = 6'b010000,
      PH_SKIP  = 6'b100000
   } phase_type;

   typedef enum logic [3:0] {
      OP_NONE   = 4'b0001,
      OP_PAGE   = 4'b0010,
      OP_REGION = 4'b0100,
      OP_FULL   = 4'b1000
   } op_type;

   typedef enum logic [3:0] {
      SL_AWAKE  = 4'b0001,
      SL_ENTER  = 4'b0010,
      SL_ASLEEP = 4'b0100,
      SL_LEAVE  = 4'b1000
   } sleep_type;

endpackage

// >>> src/serial_flash_write_erase_sleep_seq.sv
// Serial NOR flash slave: fast fetch, page write, region and full wipe, deep sleep.
// Assumes an SPI host on the link pins, slow against the 20 MHz system clock.
// Notes on behaviour
// - fetch is command, address, dummy, then data.
// - fetch address increments and wraps to zero.
// - chip select high stops read data drive.
// - fetch or sleep rejected while cycle runs.
// - address bits 23 down to 17 ignored.
// - writes and wipes need write unlock flag.
// - page write data wraps within its page.
// - last 256 bytes kept, others untouched.
// - page write needs select rise on byte boundary.
// - busy flag high during self-timed cycle.
// - write unlock flag cleared before cycle ends.
// - protected sectors refuse page write and wipe.
// - region wipe sets whole sector to ones.
// - region wipe needs rise after address byte.
// - full wipe is one byte, sets all ones.
// - full wipe only when both guard bits zero.
// - sleep entered fixed delay after select rise.
// - asleep, only the wake command is obeyed.
// - select high means standby unless cycle runs or sleep state is not awake.
// - reset starts in standby, not deep sleep.
// - wake from sleep takes a release delay.
`timescale 1ns/10ps
`include "flash_seq_defines.svh"

module serial_flash_write_erase_sleep_seq
   import flash_seq_pkg::*;
#(
   parameter int          ADDR_W   = `ADDR_BITS,
   parameter int          PAGE_W   = `PAGE_BITS,
   parameter int          SECTOR_W = `SECTOR_BITS,
   parameter int unsigned PP_CYC   = `T_PP_CYC,
   parameter int unsigned SE_CYC   = `T_SE_CYC,
   parameter int unsigned BE_CYC   = `T_BE_CYC
) (
   input  wire logic          clk_sys_in,
   input  wire logic          resetn_in,
   input  wire link_pins_type link_pins_in,
   input  wire guard_type     guard_in,
   output logic               sdo_out,
   output logic               sdo_oe_n_out,
   output logic               busy_flag_out,
   output logic               write_unlock_flag_out,
   output logic               deep_sleep_out,
   output logic               standby_out
);

   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!resetn_in);

   function automatic logic sector_protected(input logic [1:0] sec, input guard_type g);
      case ({g.hi, g.lo})
         2'b00:   sector_protected = 1'b0;
         2'b01:   sector_protected = (sec == 2'b11);
         2'b10:   sector_protected = sec[1];
         default: sector_protected = 1'b1;
      endcase
   endfunction

   function automatic phase_type cmd_phase(input logic [7:0] c, input logic busy,
                                           input sleep_type sl);
      if (sl != SL_AWAKE) begin
         cmd_phase = (c == `CMD_WAKE && sl != SL_LEAVE) ? PH_DONE : PH_SKIP;
      end else if (busy) begin
         cmd_phase = PH_SKIP;
      end else begin
         case (c)
            `CMD_FAST_FETCH, `CMD_PAGE_WRITE, `CMD_REGION_WIPE: cmd_phase = PH_ADDR;
            `CMD_FULL_WIPE, `CMD_SLEEP, `CMD_WRITE_UNLOCK, `CMD_WAKE: cmd_phase = PH_DONE;
            default: cmd_phase = PH_SKIP;
         endcase
      end
   endfunction

   link_pins_type          meta_reg;
   link_pins_type          sync_reg;
   guard_type              guard_meta_reg;
   guard_type              guard_sync_reg;
   logic                   sck_last_reg;
   logic                   cs_last_reg;
   logic                   cs_hi;
   logic                   cs_rise;
   logic                   sck_rise;
   logic                   sck_fall;
   logic [2:0]             bit_cnt_reg;
   logic [7:0]             shift_reg;
   logic                   rx_byte_done;
   logic [7:0]             rx_byte;
   phase_type              phase_reg;
   logic [7:0]             cmd_reg;
   logic [ADDR_W-1:0]      addr_reg;
   logic [1:0]             addr_cnt_reg;
   logic                   data_seen_reg;
   logic [PAGE_W-1:0]      wr_idx_reg;
   logic [7:0]             page_buf [0:(1<<PAGE_W)-1];
   logic [(1<<PAGE_W)-1:0] mask_reg;
   logic [7:0]             mem [0:(1<<ADDR_W)-1];
   logic                   frame_ok;
   logic                   prot_hit;
   op_type                 op_go;
   op_type                 op_reg;
   logic [ADDR_W-1:0]      wk_addr_reg;
   logic [ADDR_W:0]        wk_left_reg;
   logic [31:0]            timer_reg;
   logic [ADDR_W-1:0]      rd_addr_reg;
   logic [ADDR_W-1:0]      rd_next;
   logic [7:0]             tx_reg;
   logic [2:0]             tx_cnt_reg;
   sleep_type              sleep_reg;
   logic [15:0]            slp_cnt_reg;

   // Link pins and guard straps come from outside; only the second stage is read.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         meta_reg       <= 3'h4;
         sync_reg       <= 3'h4;
         guard_meta_reg <= 2'h0;
         guard_sync_reg <= 2'h0;
         sck_last_reg   <= 1'b0;
         cs_last_reg    <= 1'b1;
      end else begin
         meta_reg       <= link_pins_in;
         sync_reg       <= meta_reg;
         guard_meta_reg <= guard_in;
         guard_sync_reg <= guard_meta_reg;
         sck_last_reg   <= sync_reg.sck;
         cs_last_reg    <= sync_reg.cs_n;
      end
   end

   assign cs_hi        = sync_reg.cs_n;
   assign cs_rise      = cs_hi && !cs_last_reg;
   assign sck_rise     = !cs_hi && sync_reg.sck && !sck_last_reg;
   assign sck_fall     = !cs_hi && !sync_reg.sck && sck_last_reg;
   assign rx_byte_done = sck_rise && bit_cnt_reg == 3'h7;
   assign rx_byte      = {shift_reg[6:0], sync_reg.sdi};

   // Input bits are taken on rising link clock edges.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in || cs_hi) begin
         bit_cnt_reg <= 3'h0;
         shift_reg   <= 8'h00;
      end else if (sck_rise) begin
         bit_cnt_reg <= bit_cnt_reg + 3'h1;
         shift_reg   <= rx_byte;
      end
   end

   // Frame decoder; a deselect always returns it to the command byte.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in || cs_hi) begin
         phase_reg     <= PH_CMD;
         addr_cnt_reg  <= 2'h0;
         data_seen_reg <= 1'b0;
         if (!resetn_in) begin
            cmd_reg  <= 8'h00;
            addr_reg <= '0;
         end
      end else if (rx_byte_done) begin
         case (phase_reg)
            PH_CMD: begin
               cmd_reg   <= rx_byte;
               phase_reg <= cmd_phase(rx_byte, busy_flag_out, sleep_reg);
            end
            PH_ADDR: begin
               // Only the low address bits are kept, so the top ones fall away.
               addr_reg     <= {addr_reg[ADDR_W-9:0], rx_byte};
               addr_cnt_reg <= addr_cnt_reg + 2'h1;
               if (addr_cnt_reg == 2'h2) begin
                  case (cmd_reg)
                     `CMD_FAST_FETCH: phase_reg <= PH_DUMMY;
                     `CMD_PAGE_WRITE: phase_reg <= PH_DATA;
                     default:         phase_reg <= PH_DONE;
                  endcase
               end
            end
            PH_DUMMY: phase_reg <= PH_DATA;
            PH_DATA:  data_seen_reg <= 1'b1;
            PH_DONE:  phase_reg <= PH_SKIP;
            PH_SKIP:  phase_reg <= PH_SKIP;
            default:  phase_reg <= PH_SKIP;
         endcase
      end
   end

   // Page data lands in a buffer indexed by the low address bits, wrapping in the page.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         wr_idx_reg <= '0;
         mask_reg   <= '0;
      end else if (rx_byte_done && cmd_reg == `CMD_PAGE_WRITE) begin
         if (phase_reg == PH_ADDR && addr_cnt_reg == 2'h2) begin
            wr_idx_reg <= rx_byte[PAGE_W-1:0];
            mask_reg   <= '0;
         end else if (phase_reg == PH_DATA) begin
            wr_idx_reg           <= wr_idx_reg + 1'b1;
            mask_reg[wr_idx_reg] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (rx_byte_done && phase_reg == PH_DATA && cmd_reg == `CMD_PAGE_WRITE) begin
         page_buf[wr_idx_reg] <= rx_byte;
      end
   end

   // A command counts only when select rises on a byte boundary in a closing phase.
   assign frame_ok = cs_rise && bit_cnt_reg == 3'h0 && (phase_reg == PH_DONE ||
                     (phase_reg == PH_DATA && cmd_reg == `CMD_PAGE_WRITE && data_seen_reg));
   assign prot_hit = sector_protected(addr_reg[ADDR_W-1 -: 2], guard_sync_reg);

   always_comb begin
      op_go = OP_NONE;
      if (frame_ok && write_unlock_flag_out) begin
         case (cmd_reg)
            `CMD_PAGE_WRITE:  op_go = prot_hit ? OP_NONE : OP_PAGE;
            `CMD_REGION_WIPE: op_go = prot_hit ? OP_NONE : OP_REGION;
            `CMD_FULL_WIPE:   op_go = (guard_sync_reg == 2'b00) ? OP_FULL : OP_NONE;
            default:          op_go = OP_NONE;
         endcase
      end
   end

   // The flag drops as a cycle starts, well before that cycle ends.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         write_unlock_flag_out <= 1'b0;
      end else if (op_go != OP_NONE) begin
         write_unlock_flag_out <= 1'b0;
      end else if (frame_ok && cmd_reg == `CMD_WRITE_UNLOCK) begin
         write_unlock_flag_out <= 1'b1;
      end
   end

   // Self-timed cycle: walk the target bytes while the cycle time counts down; end when both finish.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         op_reg        <= OP_NONE;
         wk_addr_reg   <= '0;
         wk_left_reg   <= '0;
         timer_reg     <= 32'h0;
         busy_flag_out <= 1'b0;
      end else if (op_go != OP_NONE) begin
         op_reg        <= op_go;
         busy_flag_out <= 1'b1;
         case (op_go)
            OP_PAGE: begin
               wk_addr_reg <= {addr_reg[ADDR_W-1:PAGE_W], PAGE_W'(0)};
               wk_left_reg <= (ADDR_W+1)'(1) << PAGE_W;
               timer_reg   <= PP_CYC;
            end
            OP_REGION: begin
               wk_addr_reg <= {addr_reg[ADDR_W-1:SECTOR_W], SECTOR_W'(0)};
               wk_left_reg <= (ADDR_W+1)'(1) << SECTOR_W;
               timer_reg   <= SE_CYC;
            end
            default: begin
               wk_addr_reg <= '0;
               wk_left_reg <= (ADDR_W+1)'(1) << ADDR_W;
               timer_reg   <= BE_CYC;
            end
         endcase
      end else if (op_reg != OP_NONE) begin
         if (wk_left_reg != '0) begin
            wk_addr_reg <= wk_addr_reg + 1'b1;
            wk_left_reg <= wk_left_reg - 1'b1;
         end
         if (timer_reg != 32'h0) begin
            timer_reg <= timer_reg - 32'h1;
         end
         if (wk_left_reg == '0 && timer_reg == 32'h0) begin
            op_reg        <= OP_NONE;
            busy_flag_out <= 1'b0;
         end
      end
   end

   // Programming can only clear bits; the array is not reset, so wipe it before use.
   always_ff @(posedge clk_sys_in) begin
      if (op_reg != OP_NONE && wk_left_reg != '0) begin
         if (op_reg == OP_PAGE) begin
            if (mask_reg[wk_addr_reg[PAGE_W-1:0]]) begin
               mem[wk_addr_reg] <= mem[wk_addr_reg] & page_buf[wk_addr_reg[PAGE_W-1:0]];
            end
         end else begin
            mem[wk_addr_reg] <= `ERASED_BYTE;
         end
      end
   end

   // Read data leaves on falling link clock edges; no cycle runs while it does.
   assign rd_next = ADDR_W'(rd_addr_reg + 1'b1);

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in || cs_hi) begin
         sdo_oe_n_out <= 1'b1;
         tx_cnt_reg   <= 3'h0;
         if (!resetn_in) begin
            sdo_out     <= 1'b0;
            tx_reg      <= 8'h00;
            rd_addr_reg <= '0;
         end
      end else if (rx_byte_done && phase_reg == PH_DUMMY) begin
         rd_addr_reg <= addr_reg;
         tx_reg      <= mem[addr_reg];
      end else if (sck_fall && phase_reg == PH_DATA && cmd_reg == `CMD_FAST_FETCH) begin
         sdo_out      <= tx_reg[7];
         sdo_oe_n_out <= 1'b0;
         tx_cnt_reg   <= tx_cnt_reg + 3'h1;
         if (tx_cnt_reg == 3'h7) begin
            rd_addr_reg <= rd_next;
            tx_reg      <= mem[rd_next];
         end else begin
            tx_reg <= {tx_reg[6:0], 1'b0};
         end
      end
   end

   // Sleep entry and release both run on fixed delays from the select rise.
   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         sleep_reg      <= SL_AWAKE;
         slp_cnt_reg    <= 16'h0;
         deep_sleep_out <= 1'b0;
      end else if (frame_ok && cmd_reg == `CMD_WAKE && sleep_reg != SL_AWAKE) begin
         sleep_reg   <= SL_LEAVE;
         slp_cnt_reg <= 16'(`T_WAKE_CYC - 1);
      end else if (frame_ok && cmd_reg == `CMD_SLEEP && sleep_reg == SL_AWAKE) begin
         sleep_reg   <= SL_ENTER;
         slp_cnt_reg <= 16'(`T_SLEEP_CYC - 1);
      end else begin
         case (sleep_reg)
            SL_ENTER: begin
               slp_cnt_reg <= slp_cnt_reg - 16'h1;
               if (slp_cnt_reg == 16'h0) begin
                  sleep_reg      <= SL_ASLEEP;
                  deep_sleep_out <= 1'b1;
               end
            end
            SL_LEAVE: begin
               slp_cnt_reg <= slp_cnt_reg - 16'h1;
               if (slp_cnt_reg == 16'h0) begin
                  sleep_reg      <= SL_AWAKE;
                  deep_sleep_out <= 1'b0;
               end
            end
            SL_AWAKE:  sleep_reg <= SL_AWAKE;
            SL_ASLEEP: sleep_reg <= SL_ASLEEP;
            default:   sleep_reg <= SL_AWAKE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!resetn_in) begin
         standby_out <= 1'b0;
      end else begin
         standby_out <= cs_hi && op_reg == OP_NONE && sleep_reg == SL_AWAKE;
      end
   end

   property p_oe_off;
      cs_hi |=> sdo_oe_n_out;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("Read data driven while deselected.");

   property p_busy_start;
      (op_go != OP_NONE) |=> busy_flag_out && !write_unlock_flag_out;
   endproperty
   a_busy_start: assert property (p_busy_start) else $error("Cycle start mishandled.");

   property p_busy_end;
      $fell(busy_flag_out) |-> $past(wk_left_reg) == '0 && $past(timer_reg) == 32'h0;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("Busy dropped too early.");

   property p_unlock_needed;
      $rose(busy_flag_out) |-> $past(write_unlock_flag_out);
   endproperty
   a_unlock_needed: assert property (p_unlock_needed) else $error("Cycle without unlock.");

   property p_full_guard;
      $rose(busy_flag_out) && op_reg == OP_FULL |-> $past(guard_sync_reg) == 2'b00;
   endproperty
   a_full_guard: assert property (p_full_guard) else $error("Full wipe while guarded.");

   property p_guard;
      $rose(busy_flag_out) && (op_reg == OP_PAGE || op_reg == OP_REGION) |->
         !sector_protected(wk_addr_reg[ADDR_W-1 -: 2], $past(guard_sync_reg));
   endproperty
   a_guard: assert property (p_guard) else $error("Protected sector altered.");

   property p_busy_reject;
      (rx_byte_done && phase_reg == PH_CMD && busy_flag_out) |=> phase_reg == PH_SKIP;
   endproperty
   a_busy_reject: assert property (p_busy_reject) else $error("Command taken while busy.");

   property p_sleep_only_wake;
      (rx_byte_done && phase_reg == PH_CMD && sleep_reg == SL_ASLEEP && rx_byte != `CMD_WAKE)
         |=> phase_reg == PH_SKIP;
   endproperty
   a_sleep_only_wake: assert property (p_sleep_only_wake) else $error("Obeyed while asleep.");

   property p_addr_step;
      (sck_fall && phase_reg == PH_DATA && cmd_reg == `CMD_FAST_FETCH && tx_cnt_reg == 3'h7)
         |=> rd_addr_reg == ADDR_W'($past(rd_addr_reg) + 1'b1);
   endproperty
   a_addr_step: assert property (p_addr_step) else $error("Fetch address did not step.");

   property p_sleep_delay;
      (sleep_reg == SL_ENTER && slp_cnt_reg == 16'h0 && !cs_rise) |=> deep_sleep_out;
   endproperty
   a_sleep_delay: assert property (p_sleep_delay) else $error("Sleep not entered on time.");

endmodule // serial_flash_write_erase_sleep_seq

// >>> verif/spi_host_model.sv
// SPI host model that drives the link pins of the flash sequencer.
// Assumes the device's system clock; sck runs at 400 ns in mode 0.
`timescale 1ns/10ps
module spi_host_model
   import flash_seq_pkg::*;
(
   input  wire logic     clk_in,
   input  wire logic     sdo_in,
   output link_pins_type pins_out
);
   initial pins_out = '{cs_n: 1'b1, sck: 1'b0, sdi: 1'b0};

   // Shifts n bits MSB first; sdo is sampled late in the low phase.
   task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
      for (int i = 7; i > 7 - n; i--) begin
         pins_out.cs_n <= 1'b0;
         pins_out.sdi  <= tx[i];
         repeat (4) @(posedge clk_in);
         #1 rx[i] = sdo_in;
         @(posedge clk_in);
         pins_out.sck <= 1'b1;
         repeat (3) @(posedge clk_in);
         pins_out.sck <= 1'b0;
      end
   endtask

   // Select rises four clocks after the last bit, with sdi flipped; six deselected clocks follow.
   task automatic close();
      repeat (4) @(posedge clk_in);
      pins_out.cs_n <= 1'b1;
      pins_out.sdi  <= ~pins_out.sdi;
      repeat (6) @(posedge clk_in);
   endtask
endmodule // spi_host_model

// >>> verif/serial_flash_write_erase_sleep_seq_tb_top.sv
// Self-checking bench of the serial flash sequencer.
// Assumes a reduced array (12 address bits) and short cycle counts.
`timescale 1ns/10ps
`include "flash_seq_defines.svh"
module serial_flash_write_erase_sleep_seq_tb_top;
   import flash_seq_pkg::*;

   typedef struct packed {
      logic [7:0]  cmd;
      guard_type   g;
      logic        unl;
      logic [23:0] a;
      logic [7:0]  d;
      logic        bsy;
      logic [23:0] ra;
      logic [7:0]  rv;
   } row_type;

   logic          clk_sys;
   logic          resetn;
   link_pins_type pins;
   guard_type     guard;
   logic          sdo;
   logic          sdo_oe_n;
   logic          busy;
   logic          unl;
   logic          deep;
   logic          standby;
   logic [7:0]    rx;
   logic [7:0]    rd [256];
   int            n_mismatch;
   int            tests_run;

   row_type rows [9] = '{
      '{`CMD_FULL_WIPE, 2'h0, 1'b1, 24'h0, 8'h0, 1'b1, 24'h0007FF, 8'hFF},
      '{`CMD_PAGE_WRITE, 2'h0, 1'b1, 24'hFE0000, 8'h5A, 1'b1, 24'h0, 8'h5A},
      '{`CMD_PAGE_WRITE, 2'h0, 1'b0, 24'h1, 8'h11, 1'b0, 24'h1, 8'hFF},
      '{`CMD_PAGE_WRITE, 2'h1, 1'b1, 24'hC10, 8'h22, 1'b0, 24'hC10, 8'hFF},
      '{`CMD_PAGE_WRITE, 2'h1, 1'b1, 24'h810, 8'h33, 1'b1, 24'h810, 8'h33},
      '{`CMD_PAGE_WRITE, 2'h2, 1'b1, 24'h820, 8'h44, 1'b0, 24'h820, 8'hFF},
      '{`CMD_PAGE_WRITE, 2'h3, 1'b1, 24'h30, 8'h55, 1'b0, 24'h30, 8'hFF},
      '{`CMD_FULL_WIPE, 2'h1, 1'b1, 24'h0, 8'h0, 1'b0, 24'h810, 8'h33},
      '{`CMD_REGION_WIPE, 2'h1, 1'b1, 24'hFF0A00, 8'h0, 1'b1, 24'h810, 8'hFF}
   };

   serial_flash_write_erase_sleep_seq #(
      .ADDR_W   (12),
      .SECTOR_W (10),
      .PP_CYC   (10),
      .SE_CYC   (10),
      .BE_CYC   (10)
   ) uut (
      .clk_sys_in            (clk_sys),
      .resetn_in             (resetn),
      .link_pins_in          (pins),
      .guard_in              (guard),
      .sdo_out               (sdo),
      .sdo_oe_n_out          (sdo_oe_n),
      .busy_flag_out         (busy),
      .write_unlock_flag_out (unl),
      .deep_sleep_out        (deep),
      .standby_out           (standby)
   );

   // A released data line shows the inverse of the last bit, so stale data cannot pass.
   spi_host_model host (
      .clk_in   (clk_sys),
      .sdo_in   (sdo_oe_n ? ~sdo : sdo),
      .pins_out (pins)
   );

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic cmd1(input logic [7:0] c);
      host.shift(c, 8, rx);
      host.close();
   endtask

   task automatic hdr(input logic [7:0] c, input logic [23:0] a);
      host.shift(c, 8, rx);
      for (int i = 2; i >= 0; i--) begin
         host.shift(a[8*i +: 8], 8, rx);
      end
   endtask

   task automatic fetch(input logic [23:0] a, input int n);
      hdr(`CMD_FAST_FETCH, a);
      host.shift(8'h00, 8, rx);
      for (int i = 0; i < n; i++) begin
         host.shift(8'h00, 8, rd[i]);
      end
   endtask

   // Bounded so that a stuck busy flag shows up as a mismatch.
   task automatic wait_idle();
      for (int k = 0; k < 6000 && busy !== 1'b0; k++) begin
         @(posedge clk_sys);
      end
      repeat (3) @(posedge clk_sys);
      chk("idle", 8'h00, 8'(busy));
      chk("standby", 8'h01, 8'(standby));
   endtask

   initial begin
      repeat (90000) @(posedge clk_sys);
      n_mismatch++;
      results();
   end

   initial begin
      n_mismatch = 0;
      tests_run  = 0;
      resetn     = 1'b0;
      guard      = '0;
      repeat (20) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("sleep", 8'h00, 8'(deep));
      chk("unlock", 8'h00, 8'(unl));
      chk("standby", 8'h01, 8'(standby));
      foreach (rows[i]) begin
         guard <= rows[i].g;
         if (rows[i].unl) cmd1(`CMD_WRITE_UNLOCK);
         if (rows[i].cmd == `CMD_FULL_WIPE) host.shift(rows[i].cmd, 8, rx);
         else hdr(rows[i].cmd, rows[i].a);
         if (rows[i].cmd == `CMD_PAGE_WRITE) host.shift(rows[i].d, 8, rx);
         host.close();
         chk("busy", 8'(rows[i].bsy), 8'(busy));
         wait_idle();
         chk("unlock", 8'(rows[i].unl & ~rows[i].bsy), 8'(unl));
         fetch(rows[i].ra, 1);
         host.close();
         chk("data", rows[i].rv, rd[0]);
      end
      guard <= '0;
      cmd1(`CMD_WRITE_UNLOCK);
      hdr(`CMD_PAGE_WRITE, 24'h0001FE);
      for (int k = 0; k < 258; k++) begin
         host.shift(8'(k) ^ 8'hA5, 8, rx);
      end
      host.close();
      wait_idle();
      fetch(24'h000100, 256);
      host.close();
      for (int s = 0; s < 256; s++) begin
         chk("page", 8'(s + 2) ^ 8'hA5, rd[s]);
      end
      fetch(24'h000FFF, 2);
      chk("drive", 8'h00, 8'(sdo_oe_n));
      host.shift(8'h00, 3, rx);
      host.close();
      chk("top", 8'hFF, rd[0]);
      chk("wrap", 8'h5A, rd[1]);
      chk("release", 8'h01, 8'(sdo_oe_n));
      cmd1(`CMD_WRITE_UNLOCK);
      hdr(`CMD_PAGE_WRITE, 24'h000200);
      host.shift(8'h77, 8, rx);
      host.shift(8'h00, 4, rx);
      host.close();
      chk("partial", 8'h00, 8'(busy));
      chk("kept", 8'h01, 8'(unl));
      hdr(`CMD_REGION_WIPE, 24'h000100);
      host.close();
      chk("busy", 8'h01, 8'(busy));
      fetch(24'h000100, 1);
      chk("reject", 8'h01, 8'(sdo_oe_n));
      host.close();
      cmd1(`CMD_SLEEP);
      repeat (`T_SLEEP_CYC + 4) @(posedge clk_sys);
      chk("nosleep", 8'h00, 8'(deep));
      chk("running", 8'h01, 8'(busy));
      chk("standby", 8'h00, 8'(standby));
      wait_idle();
      fetch(24'h0001AB, 1);
      host.close();
      chk("wiped", 8'hFF, rd[0]);
      cmd1(`CMD_SLEEP);
      chk("entry", 8'h00, 8'(deep));
      repeat (`T_SLEEP_CYC) @(posedge clk_sys);
      chk("asleep", 8'h01, 8'(deep));
      cmd1(`CMD_WRITE_UNLOCK);
      chk("ignored", 8'h00, 8'(unl));
      cmd1(`CMD_WAKE);
      repeat (`T_WAKE_CYC + 4) @(posedge clk_sys);
      chk("awake", 8'h00, 8'(deep));
      chk("standby", 8'h01, 8'(standby));
      cmd1(`CMD_SLEEP);
      repeat (`T_SLEEP_CYC + 4) @(posedge clk_sys);
      chk("asleep", 8'h01, 8'(deep));
      resetn <= 1'b0;
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("reset", 8'h00, 8'(deep));
      chk("standby", 8'h01, 8'(standby));
      results();
   end
endmodule // serial_flash_write_erase_sleep_seq_tb_top
